// ### clk_cfg_pkg.sv
/*
 * Shared definitions for the output stop, pin function and bus address register bank,
 * plus the pin code and source decode functions used by the bank and by the per-pin drive decoder.
 * Assumes one 100 MHz clock and a synchronous, active-low reset supplied by the bank.
 */
package clk_cfg_pkg;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [6:0] OFS_MUX_DEF = 7'h08;
	localparam logic [6:0] OFS_STOP_LO = 7'h09;
	localparam logic [6:0] OFS_STOP_HI = 7'h0a;
	localparam logic [6:0] OFS_PIN_CFG_A = 7'h0b;
	localparam logic [6:0] OFS_PIN_CFG_B = 7'h0c;
	localparam logic [6:0] OFS_PIN0_SEL = 7'h0d;
	localparam logic [6:0] OFS_PIN1_SEL = 7'h0e;
	localparam logic [6:0] OFS_PIN2_SEL = 7'h0f;
	localparam logic [6:0] OFS_PIN3_SEL = 7'h10;
	localparam logic [6:0] OFS_BUS_ADDR = 7'h11;

	// ------------------------------------------------------------------
	// Field layouts and reset values
	// ------------------------------------------------------------------
	localparam int MUX_D_LSB = 0;
	localparam int MUX_E_LSB = 2;
	localparam int MUX_F_LSB = 4;
	localparam logic [7:0] MUX_WR_MASK = 8'h3f;
	localparam logic [7:0] STOP_HI_WR_MASK = 8'h03;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [4:0] BUS_ADDR_HI_RESET = 5'h1d;
	localparam logic [3:0] STOP_SRC_REGISTER = 4'h1;

	// Status space followed by status-output pins: 32 registers from 0x40.
	localparam int STATUS_REGS = 32;
	localparam logic [4:0] STATUS_IDX_CFG = 5'h00;
	localparam logic [4:0] STATUS_IDX_PIN_STATE = 5'h01;
	localparam logic [4:0] STATUS_IDX_IRQ = 5'h02;
	localparam logic [4:0] STATUS_IDX_PLL_IRQ_EN = 5'h1f;
	localparam logic [7:0] STATUS_IMPL_CFG = 8'hbf;
	localparam logic [7:0] STATUS_IMPL_IRQ = 8'h37;
	localparam logic [7:0] STATUS_IMPL_OTHER = 8'hff;

	// ------------------------------------------------------------------
	// Output group sources and pin functions
	// ------------------------------------------------------------------
	localparam logic [1:0] SRC_INTEGER = 2'h0;
	localparam logic [1:0] SRC_FRAC_BYPASS = 2'h1;
	localparam logic [1:0] SRC_PATH2 = 2'h3;

	typedef enum logic [1:0] {
		ROUTE_INTEGER,
		ROUTE_FRAC_BYPASS,
		ROUTE_PATH2,
		ROUTE_NONE
	} group_route_e;

	typedef enum logic [3:0] {
		PM_INPUT,
		PM_INPUT_INV,
		PM_DRIVE_LOW,
		PM_DRIVE_HIGH,
		PM_FOLLOW_TRUE,
		PM_FOLLOW_INV,
		PM_FOLLOW_LOW_Z,
		PM_FOLLOW_Z_LOW,
		PM_RESERVED
	} pin_mode_e;

	typedef struct packed {
		logic [3:0] code;
		logic [4:0] reg_sel;
		logic [2:0] bit_sel;
	} pin_cfg_s;

	typedef struct packed {
		logic drive;
		logic oe_n;
		logic level;
	} pin_drive_s;

	function automatic pin_mode_e pin_mode(input logic [3:0] code);
		case (code)
			4'h0: pin_mode = PM_INPUT;
			4'h1: pin_mode = PM_INPUT_INV;
			4'h2: pin_mode = PM_DRIVE_LOW;
			4'h3: pin_mode = PM_DRIVE_HIGH;
			4'h4: pin_mode = PM_FOLLOW_TRUE;
			4'h5: pin_mode = PM_FOLLOW_INV;
			4'h6: pin_mode = PM_FOLLOW_LOW_Z;
			4'h7: pin_mode = PM_FOLLOW_Z_LOW;
			default: pin_mode = PM_RESERVED;
		endcase
	endfunction

	function automatic group_route_e group_route(input logic [1:0] sel);
		case (sel)
			SRC_INTEGER: group_route = ROUTE_INTEGER;
			SRC_FRAC_BYPASS: group_route = ROUTE_FRAC_BYPASS;
			SRC_PATH2: group_route = ROUTE_PATH2;
			default: group_route = ROUTE_NONE;
		endcase
	endfunction

endpackage

// ### output_stop_gpio_config_regs.sv
/*
 * Register bank for output group source selects, per-output stop bits, four
 * general-purpose pin functions with status following, and the serial bus address.
 * Assumes a simple synchronous register port from the processor interface, pins
 * synchronous to mclk, and register hard/soft reset levels from the master config.
 */
// Operation
// - Source code 00 integer, 01 fractional, 11 path2
// - Mux register: F 5:4, E 3:2, D 1:0
// - Stop bit ORed with global stop when source 0001
// - Stop bits: outputs 8..1 low, 10..9 high
// - Pin codes 0000-0011: input, inverted, low, high
// - Codes 0100-0111 follow a chosen status bit
// - Codes 1000-1111 reserved, pin left input
// - Pin fields: odd pin high nibble, even low
// - Pin level always readable as status
// - Select field: register 0x40 plus bits 7:3
// - Bit select 000 bit0 through 111 bit7
// - Unimplemented status location is followed as 0
// - Pin status and PLL enables not selectable
// - Each pin has its own select register
// - Address in bits 6:0, bit 7 reads zero
// - Reset loads fixed high bits, pins low
// - Register resets leave the address alone
// - Rewritten address takes effect immediately
// - Global stop halts outputs with source 0001
// - Pin status shows raw level, no inversion
`timescale 1ns/1ns

module output_stop_gpio_config_regs
	import clk_cfg_pkg::*;
(
	// Clock and hardware reset
	input wire logic mclk,
	input wire logic hardware_reset_pin,
	// Register port
	input wire logic [6:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// Master configuration levels
	input wire logic register_hard_reset,
	input wire logic register_soft_reset,
	input wire logic global_output_stop,
	input wire logic [39:0] stop_source_select,
	// Strap pins and status space
	input wire logic interface_select_pin_1,
	input wire logic interface_select_pin_0,
	input wire logic [STATUS_REGS*8-1:0] status_space,
	// General-purpose pins
	input wire logic [3:0] gpio_in,
	output logic [3:0] gpio_out,
	output logic [3:0] gpio_oe_n,
	output logic [3:0] gpio_level,
	output logic [3:0] pin_state_status,
	// Output control
	output logic [9:0] output_stop,
	output logic [1:0] group_d_source_sel,
	output logic [1:0] group_e_source_sel,
	output logic [1:0] group_f_source_sel,
	output group_route_e group_d_route,
	output group_route_e group_e_route,
	output group_route_e group_f_route,
	output logic [6:0] bus_address_field
);

	// ------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------
	logic [7:0] mux_r;
	logic [7:0] stop_lo_r;
	logic [7:0] stop_hi_r;
	logic [7:0] cfg_a_r;
	logic [7:0] cfg_b_r;
	logic [7:0] sel_r [4];
	logic [6:0] addr_r;
	logic cfg_clear;
	logic [9:0] stop_bits;
	pin_cfg_s pin_cfg [4];
	pin_drive_s pin_res [4];

	function automatic logic hit(input logic [6:0] ofs);
		hit = reg_wr && (reg_addr == ofs);
	endfunction

	// Hard reset pin and both register resets return configuration to default.
	assign cfg_clear = !hardware_reset_pin || register_hard_reset || register_soft_reset;

	always_ff @(posedge mclk) begin
		if (cfg_clear) begin
			mux_r <= CFG_RESET;
		end else if (hit(OFS_MUX_DEF)) begin
			mux_r <= reg_wdata & MUX_WR_MASK;
		end
	end

	always_ff @(posedge mclk) begin
		if (cfg_clear) begin
			stop_lo_r <= CFG_RESET;
			stop_hi_r <= CFG_RESET;
		end else begin
			if (hit(OFS_STOP_LO)) begin
				stop_lo_r <= reg_wdata;
			end
			if (hit(OFS_STOP_HI)) begin
				stop_hi_r <= reg_wdata & STOP_HI_WR_MASK;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (cfg_clear) begin
			cfg_a_r <= CFG_RESET;
			cfg_b_r <= CFG_RESET;
		end else begin
			if (hit(OFS_PIN_CFG_A)) begin
				cfg_a_r <= reg_wdata;
			end
			if (hit(OFS_PIN_CFG_B)) begin
				cfg_b_r <= reg_wdata;
			end
		end
	end

	// Each pin owns one select register at consecutive offsets.
	generate
		for (genvar p = 0; p < 4; p++) begin : g_sel
			always_ff @(posedge mclk) begin
				if (cfg_clear) begin
					sel_r[p] <= CFG_RESET;
				end else if (hit(OFS_PIN0_SEL + 7'(p))) begin
					sel_r[p] <= reg_wdata;
				end
			end
		end
	endgenerate

	// The address is touched only by the reset pin and by software writes.
	always_ff @(posedge mclk) begin
		if (!hardware_reset_pin) begin
			addr_r <= {BUS_ADDR_HI_RESET, interface_select_pin_1, interface_select_pin_0};
		end else if (hit(OFS_BUS_ADDR)) begin
			addr_r <= reg_wdata[6:0];
		end
	end

	// ------------------------------------------------------------------
	// Register read-back
	// ------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!hardware_reset_pin) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				case (reg_addr)
					OFS_MUX_DEF: reg_rdata <= mux_r;
					OFS_STOP_LO: reg_rdata <= stop_lo_r;
					OFS_STOP_HI: reg_rdata <= stop_hi_r;
					OFS_PIN_CFG_A: reg_rdata <= cfg_a_r;
					OFS_PIN_CFG_B: reg_rdata <= cfg_b_r;
					OFS_PIN0_SEL: reg_rdata <= sel_r[0];
					OFS_PIN1_SEL: reg_rdata <= sel_r[1];
					OFS_PIN2_SEL: reg_rdata <= sel_r[2];
					OFS_PIN3_SEL: reg_rdata <= sel_r[3];
					OFS_BUS_ADDR: reg_rdata <= {1'b0, addr_r};
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Output group sources and stops
	// ------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!hardware_reset_pin) begin
			group_d_source_sel <= SRC_INTEGER;
			group_e_source_sel <= SRC_INTEGER;
			group_f_source_sel <= SRC_INTEGER;
			group_d_route <= ROUTE_INTEGER;
			group_e_route <= ROUTE_INTEGER;
			group_f_route <= ROUTE_INTEGER;
		end else begin
			group_d_source_sel <= mux_r[MUX_D_LSB +: 2];
			group_e_source_sel <= mux_r[MUX_E_LSB +: 2];
			group_f_source_sel <= mux_r[MUX_F_LSB +: 2];
			group_d_route <= group_route(mux_r[MUX_D_LSB +: 2]);
			group_e_route <= group_route(mux_r[MUX_E_LSB +: 2]);
			group_f_route <= group_route(mux_r[MUX_F_LSB +: 2]);
		end
	end

	assign stop_bits = {stop_hi_r[1:0], stop_lo_r};

	generate
		for (genvar o = 0; o < 10; o++) begin : g_stop
			always_ff @(posedge mclk) begin
				if (!hardware_reset_pin) begin
					output_stop[o] <= 1'b0;
				end else begin
					output_stop[o] <= (stop_source_select[o*4 +: 4] == STOP_SRC_REGISTER)
						&& (stop_bits[o] || global_output_stop);
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (!hardware_reset_pin) begin
			bus_address_field <= 7'h00;
		end else begin
			bus_address_field <= addr_r;
		end
	end

	// ------------------------------------------------------------------
	// Status following and pin drive
	// ------------------------------------------------------------------
	// The status word is an argument so that a pin re-evaluates when only a status bit moves.
	function automatic logic status_pick(input logic [STATUS_REGS*8-1:0] space,
		input logic [4:0] rsel, input logic [2:0] bsel);
		logic [7:0] impl;
		impl = STATUS_IMPL_OTHER;
		if (rsel == STATUS_IDX_CFG) begin
			impl = STATUS_IMPL_CFG;
		end else if (rsel == STATUS_IDX_IRQ) begin
			impl = STATUS_IMPL_IRQ;
		end else if (rsel == STATUS_IDX_PIN_STATE || rsel == STATUS_IDX_PLL_IRQ_EN) begin
			impl = 8'h00;
		end
		status_pick = impl[bsel] && space[{rsel, bsel}];
	endfunction

	generate
		for (genvar p = 0; p < 4; p++) begin : g_pin
			assign pin_cfg[p].code = (p < 2) ? cfg_a_r[(p%2)*4 +: 4] : cfg_b_r[(p%2)*4 +: 4];
			assign pin_cfg[p].reg_sel = sel_r[p][7:3];
			assign pin_cfg[p].bit_sel = sel_r[p][2:0];

			pin_drive u_drive (
				.code(pin_cfg[p].code),
				.follow_bit(status_pick(status_space, pin_cfg[p].reg_sel, pin_cfg[p].bit_sel)),
				.pin_level(gpio_in[p]),
				.result(pin_res[p])
			);

			always_ff @(posedge mclk) begin
				if (!hardware_reset_pin) begin
					gpio_out[p] <= 1'b0;
					gpio_oe_n[p] <= 1'b1;
					gpio_level[p] <= 1'b0;
					pin_state_status[p] <= 1'b0;
				end else begin
					gpio_out[p] <= pin_res[p].drive;
					gpio_oe_n[p] <= pin_res[p].oe_n;
					gpio_level[p] <= pin_res[p].level;
					pin_state_status[p] <= gpio_in[p];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!hardware_reset_pin);

	sequence s_addr_write;
		reg_wr && reg_addr == OFS_BUS_ADDR && !$past(!hardware_reset_pin);
	endsequence

	sequence s_addr_seen(logic [6:0] v);
		##2 bus_address_field == v;
	endsequence

	a_addr_follows_write: assert property (s_addr_write
		|-> s_addr_seen($past(reg_wdata[6:0], 2)))
		else $error("bus address did not take written value");

	a_addr_survives_regrst: assert property ((register_soft_reset || register_hard_reset)
		&& !(reg_wr && reg_addr == OFS_BUS_ADDR) |=> addr_r == $past(addr_r))
		else $error("register reset disturbed bus address");

	a_addr_reset_load: assert property (@(posedge mclk) disable iff (1'b0)
		!hardware_reset_pin |=> addr_r == {BUS_ADDR_HI_RESET, $past(interface_select_pin_1),
		$past(interface_select_pin_0)})
		else $error("bus address reset value wrong");

	a_addr_read_zero: assert property ((reg_rd && reg_addr == OFS_BUS_ADDR)
		|=> reg_rvalid && !reg_rdata[7] && reg_rdata[6:0] == $past(addr_r))
		else $error("bus address read-back wrong");

	// Read data and its strobe arrive exactly one cycle after each read.
	a_rvalid_pulse: assert property ($past(hardware_reset_pin) |-> reg_rvalid == $past(reg_rd))
		else $error("read valid does not follow read strobe");

	a_unused_bits_zero: assert property (mux_r[7:6] == 2'h0
		&& stop_hi_r[7:2] == 6'h00)
		else $error("unused register bits hold ones");

	a_stop_or_global: assert property (global_output_stop
		&& stop_source_select[3:0] == STOP_SRC_REGISTER |=> output_stop[0])
		else $error("global stop did not stop output one");

	a_stop_bit_ten: assert property ((stop_source_select[39:36] != STOP_SRC_REGISTER)
		|=> !output_stop[9])
		else $error("output ten stopped with other stop source");

	a_mux_f_layout: assert property ((reg_wr && reg_addr == OFS_MUX_DEF)
		|-> ##2 group_f_source_sel == $past(reg_wdata[5:4], 2))
		else $error("group f source select misplaced");

	a_pin_raw_level: assert property ($past(hardware_reset_pin)
		|-> pin_state_status == $past(gpio_in))
		else $error("pin status does not show raw level");

	a_pin_level_inv: assert property (cfg_a_r[7:4] == 4'h1
		|=> gpio_level[1] == !$past(gpio_in[1]))
		else $error("inverted input level wrong on pin one");

	a_pin_drive_low: assert property ((cfg_a_r[7:4] == 4'h2)[*2]
		|-> !gpio_out[1] && !gpio_oe_n[1])
		else $error("pin one not driven low");

	a_pin_reserved: assert property (pin_mode(cfg_b_r[7:4]) == PM_RESERVED
		|=> gpio_oe_n[3])
		else $error("reserved pin code drove pin three");

	a_follow_excluded: assert property (cfg_b_r[3:0] == 4'h6
		&& (sel_r[2][7:3] == STATUS_IDX_PIN_STATE || sel_r[2][7:3] == STATUS_IDX_PLL_IRQ_EN)
		|=> !gpio_out[2] && !gpio_oe_n[2])
		else $error("excluded status bit not driven low");

	a_stop_held: assert property ((stop_source_select[31:28] == STOP_SRC_REGISTER
		&& stop_lo_r[7]) [*2] |-> output_stop[7])
		else $error("stop bit eight did not stop output eight");

endmodule

// ### output_stop_gpio_config_regs_tb.sv
/*
 * Self-checking bench for the output stop, pin function and bus address register bank.
 * Assumes the package, the pin decoder and the bank are compiled before this file.
 */
`timescale 1ns/1ns

module output_stop_gpio_config_regs_tb import clk_cfg_pkg::*;;
	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
	} row_s;

	logic mclk, hardware_reset_pin, reg_wr, reg_rd, reg_rvalid;
	logic [6:0] reg_addr, bus_address_field;
	logic [7:0] reg_wdata, reg_rdata;
	logic register_hard_reset, register_soft_reset, global_output_stop;
	logic [39:0] stop_source_select;
	logic interface_select_pin_1, interface_select_pin_0;
	logic [STATUS_REGS*8-1:0] status_space;
	logic [3:0] gpio_in, gpio_out, gpio_oe_n, gpio_level, pin_state_status;
	logic [9:0] output_stop;
	logic [1:0] group_d_source_sel, group_e_source_sel, group_f_source_sel;
	group_route_e group_d_route, group_e_route, group_f_route;
	int checked = 0;
	int fail_count = 0;

	row_s rows[11] = '{'{7'h08, 8'hff, 8'h3f}, '{7'h09, 8'ha5, 8'ha5}, '{7'h0a, 8'hff, 8'h03},
		'{7'h0b, 8'h5a, 8'h5a}, '{7'h0c, 8'hc3, 8'hc3}, '{7'h0d, 8'h9e, 8'h9e},
		'{7'h0e, 8'h71, 8'h71}, '{7'h0f, 8'h2b, 8'h2b}, '{7'h10, 8'he4, 8'he4},
		'{7'h11, 8'hff, 8'h7f}, '{7'h20, 8'hff, 8'h00}};
	group_route_e route_exp[4] = '{ROUTE_INTEGER, ROUTE_FRAC_BYPASS, ROUTE_NONE, ROUTE_PATH2};

	output_stop_gpio_config_regs dut (
		.mclk(mclk), .hardware_reset_pin(hardware_reset_pin), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.register_hard_reset(register_hard_reset), .register_soft_reset(register_soft_reset),
		.global_output_stop(global_output_stop), .stop_source_select(stop_source_select),
		.interface_select_pin_1(interface_select_pin_1),
		.interface_select_pin_0(interface_select_pin_0), .status_space(status_space),
		.gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
		.gpio_level(gpio_level), .pin_state_status(pin_state_status),
		.output_stop(output_stop), .group_d_source_sel(group_d_source_sel),
		.group_e_source_sel(group_e_source_sel), .group_f_source_sel(group_f_source_sel),
		.group_d_route(group_d_route), .group_e_route(group_e_route),
		.group_f_route(group_f_route), .bus_address_field(bus_address_field)
	);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// The read strobe is held for one edge; the answer is awaited for a few cycles at most.
	task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
		int n;
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		n = 0;
		#1;
		while (reg_rvalid !== 1'b1 && n < 4) begin
			tick(1);
			n++;
		end
		if (n == 4) begin
			fail_count++;
			$display("wrong value reg_rvalid expected 1 seen 0");
			test_done();
		end
		chk("reg_rdata", reg_rdata, exp);
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		hardware_reset_pin = 1'b0;
		reg_addr = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = '0;
		register_hard_reset = 1'b0;
		register_soft_reset = 1'b0;
		global_output_stop = 1'b0;
		stop_source_select = 40'h2111111011;
		interface_select_pin_1 = 1'b1;
		interface_select_pin_0 = 1'b0;
		status_space = '0;
		gpio_in = 4'h9;
		repeat (10) @(posedge mclk);
		hardware_reset_pin <= 1'b1;
		tick(2);
		chk("bus_address_field", bus_address_field, 16'h0076);
		for (int a = 8; a < 17; a++) begin
			rdc(a[6:0], 8'h00);
		end
		rdc(OFS_BUS_ADDR, 8'h76);
		$display("test reset done");

		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rdc(rows[i].addr, rows[i].rdata);
		end
		$display("test register rows done");

		for (int c = 0; c < 4; c++) begin
			wr(OFS_MUX_DEF, {2'b00, c[1:0], c[1:0], c[1:0]});
			tick(3);
			chk("group_d_route", group_d_route, route_exp[c]);
			chk("group_e_route", group_e_route, route_exp[c]);
			chk("group_f_route", group_f_route, route_exp[c]);
		end
		wr(OFS_MUX_DEF, 8'h36);
		tick(3);
		chk("mux_sel", {group_f_source_sel, group_e_source_sel, group_d_source_sel}, 16'h36);
		$display("test mux done");

		wr(OFS_STOP_LO, 8'h85);
		wr(OFS_STOP_HI, 8'h03);
		tick(3);
		chk("output_stop", output_stop, 16'h0181);
		@(posedge mclk);
		global_output_stop <= 1'b1;
		tick(3);
		chk("output_stop", output_stop, 16'h01fb);
		@(posedge mclk);
		global_output_stop <= 1'b0;
		$display("test stop done");

		wr(OFS_PIN_CFG_A, 8'h10);
		wr(OFS_PIN_CFG_B, 8'h32);
		tick(3);
		chk("gpio_oe_n", gpio_oe_n, 16'h3);
		chk("gpio_out", gpio_out[3:2], 16'h2);
		chk("gpio_level", gpio_level[1:0], 16'h3);
		chk("pin_state_status", pin_state_status, 16'h9);
		for (int c = 8; c < 16; c++) begin
			wr(OFS_PIN_CFG_A, {4'h0, c[3:0]});
			tick(3);
			chk("gpio_oe_n", gpio_oe_n[0], 16'h1);
		end
		chk("pin_state_status", pin_state_status, 16'h9);
		$display("test pin modes done");

		@(posedge mclk);
		status_space[29] <= 1'b1;
		status_space[8] <= 1'b1;
		status_space[248] <= 1'b1;
		status_space[6] <= 1'b1;
		wr(OFS_PIN0_SEL, 8'h1d);
		wr(OFS_PIN1_SEL, 8'h08);
		wr(OFS_PIN2_SEL, 8'hf8);
		wr(OFS_PIN3_SEL, 8'h06);
		wr(OFS_PIN_CFG_A, 8'h54);
		wr(OFS_PIN_CFG_B, 8'h76);
		tick(3);
		chk("gpio_oe_n", gpio_oe_n, 16'h8);
		chk("gpio_out", gpio_out[2:0], 16'h3);
		wr(OFS_PIN2_SEL, 8'h1d);
		wr(OFS_PIN3_SEL, 8'h1d);
		tick(3);
		chk("gpio_oe_n", gpio_oe_n, 16'h4);
		chk("gpio_out", {gpio_out[3], gpio_out[1:0]}, 16'h3);
		wr(OFS_PIN0_SEL, 8'h18);
		tick(3);
		chk("gpio_out", gpio_out[0], 16'h0);
		@(posedge mclk);
		status_space[24] <= 1'b1;
		tick(3);
		chk("gpio_out", gpio_out[0], 16'h1);
		$display("test status follow done");

		wr(OFS_BUS_ADDR, 8'h2a);
		tick(3);
		chk("bus_address_field", bus_address_field, 16'h002a);
		for (int k = 0; k < 2; k++) begin
			wr(OFS_PIN_CFG_A, 8'h23);
			@(posedge mclk);
			register_hard_reset <= (k == 0);
			register_soft_reset <= (k == 1);
			@(posedge mclk);
			register_hard_reset <= 1'b0;
			register_soft_reset <= 1'b0;
			tick(2);
			rdc(OFS_PIN_CFG_A, 8'h00);
			rdc(OFS_BUS_ADDR, 8'h2a);
		end
		@(posedge mclk);
		hardware_reset_pin <= 1'b0;
		interface_select_pin_1 <= 1'b0;
		interface_select_pin_0 <= 1'b1;
		tick(3);
		@(posedge mclk);
		hardware_reset_pin <= 1'b1;
		tick(2);
		chk("bus_address_field", bus_address_field, 16'h0075);
		rdc(OFS_STOP_LO, 8'h00);
		$display("test resets done");
		test_done();
	end
endmodule

// ### pin_drive.sv
/*
 * Combinational decoder for one general-purpose pin: turns its function code and the
 * status bit it follows into a drive value, an active-low enable and an input level.
 * Assumes the caller registers all three before they reach a pin.
 */
`timescale 1ns/1ns

module pin_drive
	import clk_cfg_pkg::*;
(
	// Configuration and sources
	input wire logic [3:0] code,
	input wire logic follow_bit,
	input wire logic pin_level,
	// Result
	output pin_drive_s result
);

	always_comb begin
		result.drive = 1'b0;
		result.oe_n = 1'b1;
		result.level = pin_level;
		case (pin_mode(code))
			PM_INPUT: begin
				result.level = pin_level;
			end
			PM_INPUT_INV: begin
				result.level = ~pin_level;
			end
			PM_DRIVE_LOW: begin
				result.oe_n = 1'b0;
			end
			PM_DRIVE_HIGH: begin
				result.drive = 1'b1;
				result.oe_n = 1'b0;
			end
			PM_FOLLOW_TRUE: begin
				result.drive = follow_bit;
				result.oe_n = 1'b0;
			end
			PM_FOLLOW_INV: begin
				result.drive = ~follow_bit;
				result.oe_n = 1'b0;
			end
			PM_FOLLOW_LOW_Z: begin
				result.oe_n = follow_bit;
			end
			PM_FOLLOW_Z_LOW: begin
				result.oe_n = ~follow_bit;
			end
			default: begin
				// Unassigned codes leave the pin an undriven plain input.
				result.level = pin_level;
			end
		endcase
	end

endmodule
